// ### verification/eeprom_link_props.sv
// Checker for the two-wire link between the bus master and the serial memory.
// Assumes the bench wires in the link signals, both clocks and the memory's busy flag.
`timescale 1ns/100ps
module eeprom_link_props (
  input wire logic clk,
  input wire logic linkClk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic devSdaOe_b,
  input wire logic writeBusy
);
  // Longest write cycle allowed here; the bench shortens the memory's count to fit.
  localparam int BUSY_MAX = 1000;
  // Steps of a transfer that several checks share.
  sequence s_busyStart;
    $rose(writeBusy);
  endsequence
  sequence s_devHeld;
    !devSdaOe_b && scl;
  endsequence
  // Memory-side checks run on the link clock; the clock line is judged on the master clock that makes it.
  // Two domains meet here, so every assertion names its own clock and reset; the cover names only its clock.
  a_busy_no_ack: assert property (@(posedge linkClk) disable iff (!rst_b) writeBusy |-> devSdaOe_b)
    else $error("memory drove data while busy");
  a_ack_held_high: assert property (@(posedge linkClk) disable iff (!rst_b) s_devHeld |=> !devSdaOe_b || !scl)
    else $error("memory let go with clock high");
  a_drive_clock_low: assert property (@(posedge linkClk) disable iff (!rst_b) $fell(devSdaOe_b) |-> !scl)
    else $error("memory drove with clock high");
  a_busy_min_len: assert property (@(posedge linkClk) disable iff (!rst_b) s_busyStart |-> writeBusy[*8])
    else $error("write cycle too short");
  a_busy_ends: assert property (@(posedge linkClk) disable iff (!rst_b) s_busyStart |-> ##[1:BUSY_MAX] !writeBusy)
    else $error("write cycle never ends");
  a_busy_bus_idle: assert property (@(posedge linkClk) disable iff (!rst_b) s_busyStart |-> scl && sda)
    else $error("write cycle began without Stop");
  a_scl_high_len: assert property (@(posedge clk) disable iff (!rst_b) $rose(scl) |-> scl[*4])
    else $error("clock high phase too short");
  a_scl_low_len: assert property (@(posedge clk) disable iff (!rst_b) $fell(scl) |-> (!scl)[*7])
    else $error("clock low phase too short");
  c_ack_seen: cover property (@(posedge linkClk) s_devHeld);
endmodule

// ### verification/i2c_eeprom_slave_access_tb.sv
// Self-checking bench: the master end and the memory end joined by one link.
// Assumes the master handshake of the package; quarter and write cycle are shortened for speed.
`timescale 1ns/100ps
module i2c_eeprom_slave_access_tb;
  logic clk = 0, linkClk = 0, rst_b = 0, cmdValid = 0, wrValid = 0, writeProtect = 0, supplyLow = 0;
  logic cmdReady, wrReady, rdValid, done, nackErr, writeBusy;
  eeprom_link_pkg::op_type cmdOp = eeprom_link_pkg::OP_WRITE;
  logic [10:0] cmdAddr = 11'h000;
  logic [7:0] cmdLen = 8'h01, wrData = 8'h00, rdData;
  logic [7:0] wq[$], rq[$];
  int num_errors = 0, num_checks = 0, cycles = 0;
  eeprom_link_if link ();
  eeprom_serial_device #(.WRITE_CYCLES(200)) i_eeprom_serial_device (.linkClk(linkClk), .rst_b(rst_b),
    .writeProtect(writeProtect), .supplyLow(supplyLow), .writeBusy(writeBusy), .link(link));
  eeprom_bus_master #(.QUARTER(8)) i_eeprom_bus_master (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData), .rdValid(rdValid), .rdData(rdData), .done(done), .nackErr(nackErr), .link(link));
  eeprom_link_props i_eeprom_link_props (.clk(clk), .linkClk(linkClk), .rst_b(rst_b), .scl(link.scl),
    .sda(link.sda), .devSdaOe_b(link.devSdaOe_b), .writeBusy(writeBusy));
  // The link clock starts off phase and runs at a 12 ns period against 25 ns, so its edges drift against the system clock.
  always #12.5 clk = ~clk;
  initial begin
    #3.1;
    forever #6 linkClk = ~linkClk;
  end
  // A hang is cut short well above the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      $display("FAIL %0t timeout", $time);
      finish_test();
    end
  end
  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One command: write bytes come from wq, read bytes land in rq; inputs move on falling edges only.
  task automatic run(eeprom_link_pkg::op_type op, logic [10:0] a, logic [7:0] n);
    logic taken;
    logic finished;
    taken = 1'b0;
    finished = 1'b0;
    rq = {};
    @(negedge clk);
    cmdOp = op;
    cmdAddr = a;
    cmdLen = n;
    cmdValid = 1'b1;
    repeat (9000) begin
      wrValid = wq.size() > 0;
      if (wq.size() > 0) wrData = wq[0];
      @(posedge clk);
      if (cmdReady === 1'b1) taken = 1'b1;
      if (wrValid && wrReady === 1'b1) void'(wq.pop_front());
      if (rdValid === 1'b1) rq.push_back(rdData);
      if (done === 1'b1 && taken) begin
        finished = 1'b1;
        break;
      end
      @(negedge clk);
      cmdValid = !taken;
    end
    chk({7'h00, nackErr}, 8'h00);
    // A command that never completes would otherwise slip silently into the next scenario.
    if (!finished) begin
      num_errors++;
      $display("FAIL %0t command never finished", $time);
      finish_test();
    end
  endtask
  task automatic page_write_test();
    wq = '{8'h11, 8'h22, 8'h33};
    run(eeprom_link_pkg::OP_WRITE, 11'h1fe, 8'h03);
    run(eeprom_link_pkg::OP_READ_RANDOM, 11'h1f0, 8'h01);
    chk(rq[0], 8'h33);
    run(eeprom_link_pkg::OP_READ_RANDOM, 11'h1fe, 8'h01);
    chk(rq[0], 8'h11);
    run(eeprom_link_pkg::OP_READ_CURRENT, 11'h000, 8'h01);
    chk(rq[0], 8'h22);
    for (int i = 1; i <= 17; i++) wq.push_back(8'(i));
    run(eeprom_link_pkg::OP_WRITE, 11'h100, 8'h11);
    run(eeprom_link_pkg::OP_READ_RANDOM, 11'h100, 8'h02);
    chk(rq[0], 8'h11);
    chk(rq[1], 8'h02);
  endtask
  task automatic wrap_test();
    wq = '{8'ha5};
    run(eeprom_link_pkg::OP_WRITE, 11'h000, 8'h01);
    wq = '{8'h5a};
    run(eeprom_link_pkg::OP_WRITE, 11'h7ff, 8'h01);
    run(eeprom_link_pkg::OP_READ_RANDOM, 11'h7ff, 8'h02);
    chk(rq[0], 8'h5a);
    chk(rq[1], 8'ha5);
  endtask
  // Protection and low supply each must leave the erased byte untouched.
  task automatic protect_test();
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      writeProtect = (i == 0);
      supplyLow = (i == 1);
      wq = '{8'h77};
      run(eeprom_link_pkg::OP_WRITE, 11'h010, 8'h01);
      @(negedge clk);
      writeProtect = 1'b0;
      supplyLow = 1'b0;
      run(eeprom_link_pkg::OP_READ_RANDOM, 11'h010, 8'h01);
      chk(rq[0], 8'hff);
    end
  endtask
  // Reset for three cycles, then the scenarios in turn.
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    page_write_test();
    wrap_test();
    protect_test();
    finish_test();
  end
endmodule

// ### verilog/eeprom_bus_master.sv
// Bus master end of the two-wire link: turns byte-level commands into Start, bytes, acks and Stop.
// Assumes the memory end acknowledges as the link defines; the serial clock is divided from clk.
`timescale 1ns/100ps
module eeprom_bus_master #(
  parameter int QUARTER = eeprom_link_pkg::QUARTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire eeprom_link_pkg::op_type cmdOp,
  input wire logic [eeprom_link_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic [7:0] cmdLen,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [7:0] wrData,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic done,
  output logic nackErr,
  eeprom_link_if.master link
);

  localparam int QW = $clog2(QUARTER + 1);

  typedef struct packed {
    eeprom_link_pkg::mst_state_type st;
    eeprom_link_pkg::step_type step;
    logic [1:0] q;
    logic [QW-1:0] qCnt;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    eeprom_link_pkg::op_type op;
    logic [eeprom_link_pkg::ADDR_W-1:0] addr;
    logic [7:0] remain;
    logic retry;
    logic ackOk;
    logic sdaOe_b;
    logic scl;
    logic [7:0] rdData;
    logic rdValid;
    logic done;
    logic nackErr;
    logic sdaS1;
    logic sdaS2;
  } mst_type;

  mst_type state_r;
  mst_type state_nxt;
  logic tick, qEnd;

  // Control byte: code, block bits as the top address bits, direction.
  function automatic logic [7:0] ctrlByte(input logic [eeprom_link_pkg::ADDR_W-1:0] a, input logic rw);
    ctrlByte = {eeprom_link_pkg::DEVICE_CODE, a[eeprom_link_pkg::ADDR_W-1:8], rw};
  endfunction

  assign tick = (state_r.qCnt == QW'(QUARTER - 1));
  assign qEnd = tick && (state_r.q == 2'h3);
  assign cmdReady = (state_r.st == eeprom_link_pkg::M_IDLE);

  // Sequencer and bit engine; each bit is four quarters with the clock high in the middle two.
  always_comb begin
    state_nxt = state_r;
    state_nxt.rdValid = 1'b0;
    state_nxt.done = 1'b0;
    state_nxt.sdaS1 = link.sda;
    state_nxt.sdaS2 = state_r.sdaS1;
    wrReady = 1'b0;
    if (state_r.st != eeprom_link_pkg::M_IDLE) begin
      state_nxt.qCnt = tick ? '0 : state_r.qCnt + 1'b1;
      state_nxt.q = tick ? state_r.q + 1'b1 : state_r.q;
    end
    case (state_r.st)
      eeprom_link_pkg::M_IDLE: begin
        if (cmdValid) begin
          state_nxt.op = cmdOp;
          state_nxt.addr = cmdAddr;
          state_nxt.remain = cmdLen;
          state_nxt.nackErr = 1'b0;
          state_nxt.retry = 1'b0;
          state_nxt.q = '0;
          state_nxt.qCnt = '0;
          state_nxt.st = eeprom_link_pkg::M_START;
          state_nxt.step = (cmdOp == eeprom_link_pkg::OP_READ_CURRENT) ?
            eeprom_link_pkg::STEP_CTRLR : eeprom_link_pkg::STEP_CTRLW;
        end
      end
      eeprom_link_pkg::M_START: begin
        if (qEnd) begin
          state_nxt.st = eeprom_link_pkg::M_TX;
          state_nxt.bitCnt = '0;
          state_nxt.shift = ctrlByte(state_r.addr, state_r.step == eeprom_link_pkg::STEP_CTRLR);
        end
      end
      eeprom_link_pkg::M_TX: begin
        if (qEnd) begin
          if (state_r.bitCnt == 3'h7) begin
            state_nxt.st = eeprom_link_pkg::M_TXACK;
          end else begin
            state_nxt.bitCnt = state_r.bitCnt + 1'b1;
            state_nxt.shift = {state_r.shift[6:0], 1'b0};
          end
        end
      end
      eeprom_link_pkg::M_TXACK: begin
        if (tick && state_r.q == 2'h2) begin
          state_nxt.ackOk = !state_r.sdaS2;
        end
        if (qEnd) begin
          if (!state_r.ackOk) begin
            // A refused control byte means a write cycle is running: stop and poll again.
            state_nxt.st = eeprom_link_pkg::M_STOP;
            if (state_r.step == eeprom_link_pkg::STEP_CTRLW || state_r.step == eeprom_link_pkg::STEP_CTRLR) begin
              state_nxt.retry = 1'b1;
            end else begin
              state_nxt.nackErr = 1'b1;
            end
          end else begin
            case (state_r.step)
              eeprom_link_pkg::STEP_CTRLW: begin
                state_nxt.step = eeprom_link_pkg::STEP_ADDR;
                state_nxt.st = eeprom_link_pkg::M_TX;
                state_nxt.bitCnt = '0;
                state_nxt.shift = state_r.addr[7:0];
              end
              eeprom_link_pkg::STEP_CTRLR: begin
                state_nxt.step = eeprom_link_pkg::STEP_RDATA;
                state_nxt.st = eeprom_link_pkg::M_RX;
                state_nxt.bitCnt = '0;
              end
              default: begin
                if (state_r.step == eeprom_link_pkg::STEP_ADDR && state_r.op != eeprom_link_pkg::OP_WRITE) begin
                  state_nxt.step = eeprom_link_pkg::STEP_CTRLR;
                  state_nxt.st = eeprom_link_pkg::M_START;
                end else if (state_r.step == eeprom_link_pkg::STEP_WDATA && state_r.remain == 8'h01) begin
                  state_nxt.remain = '0;
                  state_nxt.st = eeprom_link_pkg::M_STOP;
                end else begin
                  // The clock is held low until the next write byte arrives.
                  wrReady = 1'b1;
                  if (wrValid) begin
                    state_nxt.remain = (state_r.step == eeprom_link_pkg::STEP_WDATA) ? state_r.remain - 1'b1 : state_r.remain;
                    state_nxt.step = eeprom_link_pkg::STEP_WDATA;
                    state_nxt.st = eeprom_link_pkg::M_TX;
                    state_nxt.bitCnt = '0;
                    state_nxt.shift = wrData;
                  end else begin
                    state_nxt.q = state_r.q;
                    state_nxt.qCnt = state_r.qCnt;
                  end
                end
              end
            endcase
          end
        end
      end
      eeprom_link_pkg::M_RX: begin
        if (tick && state_r.q == 2'h2) begin
          state_nxt.shift = {state_r.shift[6:0], state_r.sdaS2};
        end
        if (qEnd) begin
          if (state_r.bitCnt == 3'h7) begin
            state_nxt.st = eeprom_link_pkg::M_RXACK;
            state_nxt.rdData = state_r.shift;
            state_nxt.rdValid = 1'b1;
            state_nxt.remain = state_r.remain - 1'b1;
            state_nxt.sdaOe_b = (state_r.remain == 8'h01);
          end else begin
            state_nxt.bitCnt = state_r.bitCnt + 1'b1;
          end
        end
      end
      eeprom_link_pkg::M_RXACK: begin
        if (qEnd) begin
          state_nxt.bitCnt = '0;
          state_nxt.st = (state_r.remain == '0) ? eeprom_link_pkg::M_STOP : eeprom_link_pkg::M_RX;
        end
      end
      eeprom_link_pkg::M_STOP: begin
        if (qEnd) begin
          state_nxt.retry = 1'b0;
          state_nxt.st = state_r.retry ? eeprom_link_pkg::M_START : eeprom_link_pkg::M_IDLE;
          state_nxt.done = !state_r.retry;
        end
      end
      default: begin
        state_nxt.st = eeprom_link_pkg::M_IDLE;
      end
    endcase

    // Pin levels follow the next state and quarter, so they change only at quarter boundaries.
    case (state_nxt.st)
      eeprom_link_pkg::M_IDLE: begin
        state_nxt.scl = 1'b1;
        state_nxt.sdaOe_b = 1'b1;
      end
      eeprom_link_pkg::M_START: begin
        state_nxt.scl = (state_nxt.q != 2'h0);
        state_nxt.sdaOe_b = (state_nxt.q < 2'h2);
      end
      eeprom_link_pkg::M_STOP: begin
        state_nxt.scl = (state_nxt.q != 2'h0);
        state_nxt.sdaOe_b = (state_nxt.q >= 2'h2);
      end
      eeprom_link_pkg::M_TX: begin
        state_nxt.scl = (state_nxt.q == 2'h1) || (state_nxt.q == 2'h2);
        state_nxt.sdaOe_b = state_nxt.shift[7];
      end
      eeprom_link_pkg::M_RXACK: begin
        state_nxt.scl = (state_nxt.q == 2'h1) || (state_nxt.q == 2'h2);
      end
      default: begin
        state_nxt.scl = (state_nxt.q == 2'h1) || (state_nxt.q == 2'h2);
        state_nxt.sdaOe_b = 1'b1;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= '0;
      state_r.scl <= 1'b1;
      state_r.sdaOe_b <= 1'b1;
      state_r.sdaS1 <= 1'b1;
      state_r.sdaS2 <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.scl = state_r.scl;
  assign link.mstSdaOut = 1'b0;
  assign link.mstSdaOe_b = state_r.sdaOe_b;
  assign rdValid = state_r.rdValid;
  assign rdData = state_r.rdData;
  assign done = state_r.done;
  assign nackErr = state_r.nackErr;

endmodule

// ### verilog/eeprom_link_if.sv
// Two-wire link between the bus master and the serial memory.
// Assumes both data-line drivers are open drain: an output enable low pulls the line to the output value.
`timescale 1ns/100ps
interface eeprom_link_if;
  logic scl;
  logic mstSdaOut;
  logic mstSdaOe_b;
  logic devSdaOut;
  logic devSdaOe_b;
  logic sda;

  // Wired-AND of both drivers with the pull-up.
  assign sda = (mstSdaOe_b | mstSdaOut) & (devSdaOe_b | devSdaOut);

  modport master (output scl, output mstSdaOut, output mstSdaOe_b, input sda);
  modport device (input scl, input sda, output devSdaOut, output devSdaOe_b);
endinterface

// ### verilog/eeprom_link_pkg.sv
// Shared constants and types for the two-wire serial memory link.
// Assumes a 40 MHz system clock at the master end and a free-running link clock at the memory end.
package eeprom_link_pkg;

  // Array organisation: eight blocks of 256 bytes, 16-byte pages.
  localparam int ADDR_W = 11;
  localparam int BLOCK_W = 3;
  localparam int PAGE_OFS_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Control byte layout: device-type code, block select, direction bit.
  localparam logic [3:0] DEVICE_CODE = 4'ha;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  // Master clock and serial clock timing; a quarter of a serial clock period is a least time.
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QUARTER_CYCLES = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Self-timed write cycle, counted on the link clock; a longest time rounds down.
  localparam int TWC_MS = 5;
  localparam int LINK_PERIOD_NS = 12;
  localparam int TWC_LINK_CYCLES = TWC_MS * 1000000 / LINK_PERIOD_NS;

  // Master command codes.
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ_RANDOM = 2'b01,
    OP_READ_CURRENT = 2'b10
  } op_type;

  // Master bit engine states.
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_TX = 3'b010,
    M_TXACK = 3'b011,
    M_RX = 3'b100,
    M_RXACK = 3'b101,
    M_STOP = 3'b110
  } mst_state_type;

  // Which byte of a transaction the master is on.
  typedef enum logic [2:0] {
    STEP_CTRLW = 3'b000,
    STEP_ADDR = 3'b001,
    STEP_WDATA = 3'b010,
    STEP_CTRLR = 3'b011,
    STEP_RDATA = 3'b100
  } step_type;

  // Memory end bus states.
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RECV = 3'b001,
    D_ACKOUT = 3'b010,
    D_SEND = 3'b011,
    D_MACK = 3'b100
  } dev_state_type;

  // Meaning of the byte being received.
  typedef enum logic [1:0] {
    K_CTRL = 2'b00,
    K_ADDR = 2'b01,
    K_DATA = 2'b10
  } kind_type;

endpackage

// ### verilog/eeprom_serial_device.sv
// Serial memory end of the two-wire link: control decode, address pointer, page buffer, write cycle.
// Assumes a free-running link clock much faster than the serial clock; rst_b comes from another domain.
// Contract
// - Master sends code, block bits, direction bit.
// - Device acknowledges each received byte when addressed.
// - Byte after write control loads address low.
// - Stop after write data starts write cycle.
// - No acknowledge at all during write cycle.
// - Up to sixteen bytes held until Stop.
// - Only four low pointer bits increment.
// - Extra bytes wrap, last sixteen kept.
// - Page writes wrap within the same page.
// - Master keeps page writes inside one page; eeprom_bus_master does not check this and sends every byte of cmdLen.
// - Polling control byte acknowledged once cycle ends.
// - Write-protect high inhibits all array writes; it is checked only at Stop, so a rise during the write cycle does not block it.
// - Reads start like writes, direction bit one.
// - Pointer holds last accessed address plus one.
// - Single read: ack, eight bits, nack, Stop.
// - Repeated start keeps pointer, writes nothing.
// - Master ack requests the next byte.
// - Pointer advances after each byte access.
// - Low supply blocks all array writes.
// - Acknowledge only matching code; block bits address.
// - After master nack, data line released.
`timescale 1ns/100ps
module eeprom_serial_device #(
  parameter int WRITE_CYCLES = eeprom_link_pkg::TWC_LINK_CYCLES
) (
  input wire logic linkClk,
  input wire logic rst_b,
  input wire logic writeProtect,
  input wire logic supplyLow,
  output logic writeBusy,
  eeprom_link_if.device link
);

  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int ADDR_W = eeprom_link_pkg::ADDR_W;
  localparam int POW = eeprom_link_pkg::PAGE_OFS_W;

  typedef struct packed {
    eeprom_link_pkg::dev_state_type st;
    eeprom_link_pkg::kind_type kind;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [ADDR_W-1:0] ptr;
    logic toSend;
    logic sdaOe_b;
    logic [eeprom_link_pkg::PAGE_BYTES-1:0][7:0] pageBuf;
    logic [eeprom_link_pkg::PAGE_BYTES-1:0] bufValid;
    logic hasData;
    logic busy;
    logic [TW-1:0] timer;
    logic [POW:0] commitIdx;
    logic [ADDR_W-POW-1:0] page;
    logic sclPrev;
    logic sdaPrev;
  } dev_type;

  dev_type state_r;
  dev_type state_nxt;
  logic [7:0] mem [2**ADDR_W];
  logic rstS1, rstS2, sclS1, sclS2, sdaS1, sdaS2, wpS1, wpS2, lowS1, lowS2;
  logic memWe;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0] memData;
  logic [7:0] rdByte;
  logic rise, fall, startCond, stopCond;

  // Everything arriving from outside the link clock domain passes two flip-flops first.
  always_ff @(posedge linkClk) begin
    rstS1 <= rst_b;
    rstS2 <= rstS1;
    sclS1 <= link.scl;
    sclS2 <= sclS1;
    sdaS1 <= link.sda;
    sdaS2 <= sdaS1;
    wpS1 <= writeProtect;
    wpS2 <= wpS1;
    lowS1 <= supplyLow;
    lowS2 <= lowS1;
  end

  // Array storage; reset leaves it erased so that reads never return unknowns.
  always_ff @(posedge linkClk) begin
    if (!rstS2) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem[i] <= eeprom_link_pkg::ERASED_BYTE;
      end
    end else if (memWe) begin
      mem[memAddr] <= memData;
    end
  end

  assign rdByte = mem[state_r.ptr];

  // Bus conditions are judged on synchronised samples only, so a spike shorter than a link clock is seen only when it spans a rising link clock edge.
  assign rise = !state_r.sclPrev & sclS2;
  assign fall = state_r.sclPrev & !sclS2;
  assign startCond = state_r.sclPrev & sclS2 & state_r.sdaPrev & !sdaS2;
  assign stopCond = state_r.sclPrev & sclS2 & !state_r.sdaPrev & sdaS2;

  // Next-state logic for the bus engine and the write cycle.
  always_comb begin
    state_nxt = state_r;
    state_nxt.sclPrev = sclS2;
    state_nxt.sdaPrev = sdaS2;
    memWe = 1'b0;
    memAddr = '0;
    memData = '0;

    // Write cycle: one buffered byte per link clock, then the timer runs out.
    if (state_r.busy) begin
      if (state_r.commitIdx < (POW + 1)'(eeprom_link_pkg::PAGE_BYTES)) begin
        memWe = state_r.bufValid[state_r.commitIdx[POW-1:0]] & !lowS2;
        memAddr = {state_r.page, state_r.commitIdx[POW-1:0]};
        memData = state_r.pageBuf[state_r.commitIdx[POW-1:0]];
        state_nxt.commitIdx = state_r.commitIdx + 1'b1;
      end
      if (state_r.timer == '0) begin
        state_nxt.busy = 1'b0;
      end else begin
        state_nxt.timer = state_r.timer - 1'b1;
      end
    end

    if (startCond) begin
      // A repeated start abandons any unwritten data but keeps the pointer.
      state_nxt.st = eeprom_link_pkg::D_RECV;
      state_nxt.kind = eeprom_link_pkg::K_CTRL;
      state_nxt.bitCnt = '0;
      state_nxt.sdaOe_b = 1'b1;
      state_nxt.hasData = 1'b0;
    end else if (stopCond) begin
      // Protection and low supply are checked at the Stop; a blocked write never becomes busy.
      if (state_r.hasData && !wpS2 && !lowS2) begin
        state_nxt.busy = 1'b1;
        state_nxt.timer = TW'(WRITE_CYCLES - 1);
        state_nxt.commitIdx = '0;
        state_nxt.page = state_r.ptr[ADDR_W-1:POW];
      end
      state_nxt.hasData = 1'b0;
      state_nxt.st = eeprom_link_pkg::D_IDLE;
      state_nxt.sdaOe_b = 1'b1;
    end else begin
      case (state_r.st)
        eeprom_link_pkg::D_RECV: begin
          if (rise) begin
            state_nxt.shift = {state_r.shift[6:0], sdaS2};
            state_nxt.bitCnt = state_r.bitCnt + 1'b1;
          end else if (fall && state_r.bitCnt == 4'h8) begin
            state_nxt.bitCnt = '0;
            state_nxt.st = eeprom_link_pkg::D_ACKOUT;
            state_nxt.sdaOe_b = 1'b0;
            state_nxt.toSend = 1'b0;
            case (state_r.kind)
              eeprom_link_pkg::K_CTRL: begin
                if (state_r.shift[7:4] != eeprom_link_pkg::DEVICE_CODE || state_r.busy) begin
                  state_nxt.st = eeprom_link_pkg::D_IDLE;
                  state_nxt.sdaOe_b = 1'b1;
                end else if (state_r.shift[0] == eeprom_link_pkg::RW_READ) begin
                  state_nxt.toSend = 1'b1;
                end else begin
                  state_nxt.ptr[ADDR_W-1:ADDR_W-eeprom_link_pkg::BLOCK_W] = state_r.shift[3:1];
                  state_nxt.kind = eeprom_link_pkg::K_ADDR;
                end
              end
              eeprom_link_pkg::K_ADDR: begin
                state_nxt.ptr[7:0] = state_r.shift;
                state_nxt.bufValid = '0;
                state_nxt.kind = eeprom_link_pkg::K_DATA;
              end
              default: begin
                // Offset wraps inside the page, so a seventeenth byte replaces the first.
                state_nxt.pageBuf[state_r.ptr[POW-1:0]] = state_r.shift;
                state_nxt.bufValid[state_r.ptr[POW-1:0]] = 1'b1;
                state_nxt.ptr[POW-1:0] = state_r.ptr[POW-1:0] + 1'b1;
                state_nxt.hasData = 1'b1;
              end
            endcase
          end
        end
        eeprom_link_pkg::D_ACKOUT: begin
          if (fall) begin
            if (state_r.toSend) begin
              state_nxt.shift = {rdByte[6:0], 1'b0};
              state_nxt.sdaOe_b = rdByte[7];
              state_nxt.bitCnt = 4'h1;
              state_nxt.ptr = state_r.ptr + 1'b1;
              state_nxt.st = eeprom_link_pkg::D_SEND;
            end else begin
              state_nxt.sdaOe_b = 1'b1;
              state_nxt.st = eeprom_link_pkg::D_RECV;
            end
          end
        end
        eeprom_link_pkg::D_SEND: begin
          if (fall) begin
            if (state_r.bitCnt == 4'h8) begin
              state_nxt.sdaOe_b = 1'b1;
              state_nxt.st = eeprom_link_pkg::D_MACK;
            end else begin
              state_nxt.sdaOe_b = state_r.shift[7];
              state_nxt.shift = {state_r.shift[6:0], 1'b0};
              state_nxt.bitCnt = state_r.bitCnt + 1'b1;
            end
          end
        end
        eeprom_link_pkg::D_MACK: begin
          if (rise && sdaS2) begin
            state_nxt.st = eeprom_link_pkg::D_IDLE;
          end else if (fall) begin
            state_nxt.shift = {rdByte[6:0], 1'b0};
            state_nxt.sdaOe_b = rdByte[7];
            state_nxt.bitCnt = 4'h1;
            state_nxt.ptr = state_r.ptr + 1'b1;
            state_nxt.st = eeprom_link_pkg::D_SEND;
          end
        end
        default: begin
          state_nxt.sdaOe_b = 1'b1;
        end
      endcase
    end
  end

  // State register; the line defaults to released and idle-high history so reset never fakes a condition.
  always_ff @(posedge linkClk) begin
    if (!rstS2) begin
      state_r <= '0;
      state_r.sdaOe_b <= 1'b1;
      state_r.sclPrev <= 1'b1;
      state_r.sdaPrev <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe_b = state_r.sdaOe_b;
  assign writeBusy = state_r.busy;

endmodule
